// ### scg_pkg.sv
/*
 * constants for the sleep-mode unit clock gating block: register map,
 * field positions, reset values, bus answer codes and state encodings.
 * assumes it is compiled before every module that imports it.
 */
package scg_pkg;

    // ************************************************************
    // bus geometry
    // ************************************************************
    localparam int SCG_ADDR_W = 12;
    localparam int SCG_DATA_W = 32;
    localparam int SCG_BE_W = 4;
    localparam int SCG_UNIT_W = 5;
    localparam int SCG_CLK_PERIOD_NS = 40;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [11:0] SCG_OFF_SLEEP_GATE = 12'h114;
    localparam logic [11:0] SCG_OFF_GATE_STATUS = 12'h118;
    localparam logic [11:0] SCG_OFF_FAULT_STATUS = 12'h11c;
    localparam logic [11:0] SCG_OFF_CLOCK_CONFIG = 12'h060;

    // ************************************************************
    // reset values and masks
    // ************************************************************
    localparam logic [31:0] SCG_SLEEP_GATE_RST = 32'h0000_0000;
    localparam logic [31:0] SCG_SLEEP_GATE_WMASK = 32'h070f_5337;
    localparam logic [31:0] SCG_ZERO_WORD = 32'h0000_0000;
    localparam logic SCG_AUTO_GATE_RST = 1'b0;

    // ************************************************************
    // gating field positions inside sleep_unit_clock_gate_1
    // ************************************************************
    localparam int SCG_BIT_COMPARATOR_2 = 26;
    localparam int SCG_BIT_COMPARATOR_1 = 25;
    localparam int SCG_BIT_COMPARATOR_0 = 24;
    localparam int SCG_BIT_GP_COUNTER_3 = 19;
    localparam int SCG_BIT_GP_COUNTER_2 = 18;
    localparam int SCG_BIT_GP_COUNTER_1 = 17;
    localparam int SCG_BIT_GP_COUNTER_0 = 16;
    localparam int SCG_BIT_TWO_WIRE_1 = 14;
    localparam int SCG_BIT_TWO_WIRE_0 = 12;
    localparam int SCG_BIT_QUAD_ENCODER_1 = 9;
    localparam int SCG_BIT_QUAD_ENCODER_0 = 8;
    localparam int SCG_BIT_SYNC_SERIAL_1 = 5;
    localparam int SCG_BIT_SYNC_SERIAL_0 = 4;
    localparam int SCG_BIT_ASYNC_SERIAL_2 = 2;
    localparam int SCG_BIT_ASYNC_SERIAL_1 = 1;
    localparam int SCG_BIT_ASYNC_SERIAL_0 = 0;

    // ************************************************************
    // other fields
    // ************************************************************
    localparam int SCG_BIT_AUTO_GATE = 0;
    localparam int SCG_BIT_FAULT_SEEN = 0;
    localparam int SCG_FAULT_UNIT_LSB = 8;

    // ************************************************************
    // avalon response codes
    // ************************************************************
    localparam logic [1:0] SCG_RESP_OKAY = 2'h0;
    localparam logic [1:0] SCG_RESP_DECODEERROR = 2'h3;

    typedef enum logic [1:0] {
        SCG_BUS_IDLE = 2'h1,
        SCG_BUS_DONE = 2'h2
    } scg_bus_state_e;

endpackage

// ### scg_fault_check.sv
/*
 * access checker for the gated peripheral units: answers each peripheral
 * access with either a normal completion or a bus fault.
 * assumes requests come from logic on the same clock, one per cycle.
 */
`timescale 1ns/1ps

module scg_fault_check
    import scg_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // access request
    input wire logic i_req,
    input wire logic [SCG_UNIT_W-1:0] i_unit,
    // live clock enables
    input wire logic [31:0] i_unit_en,
    // answer
    output logic o_done,
    output logic o_fault,
    output logic [SCG_UNIT_W-1:0] o_unit
);

    logic unit_live;

    // reserved positions never carry an enable, so they always fault
    assign unit_live = i_unit_en[i_unit];

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_done <= 1'b0;
            o_fault <= 1'b0;
            o_unit <= '0;
        end else begin
            o_done <= i_req & unit_live;
            o_fault <= i_req & ~unit_live;
            o_unit <= i_req ? i_unit : o_unit;
        end
    end

endmodule

// ### scg_sleep_gate.sv
/*
 * sleep-mode unit clock gating block: holds sleep_unit_clock_gate_1,
 * drives one clock enable per controlled unit and faults accesses to
 * units whose clock is off.
 * assumes the run-mode gating word and the sleep indication come from
 * logic on the same clock; registers are reached over avalon-mm.
 */
// The Avalon-MM slave port was chosen for this implementation.
// Function
// - a unit whose gating bit is one gets its clock enable, a zero bit turns it off.
// - an access to a unit whose clock is off ends in a bus fault, not a normal answer.
// - after reset the whole sleep gating register reads zero; unit enables reset to zero, then follow the run-mode word.
// - the sleep gating register chooses the unit enables while the system sleeps.
// - the sleep gating word is only used when the automatic gating select bit is set.
// - bits 19 to 16 gate general purpose counters 3 to 0 and reset to zero.
// - bit 14 gates two-wire module 1 and bit 12 two-wire module 0, both reset zero.
// - bits 9 and 8 gate quadrature encoders 1 and 0 and reset to zero.
// - bits 5 and 4 gate synchronous serial modules 1 and 0 and reset to zero.
// - bits 2, 1 and 0 gate asynchronous serial ports 2, 1 and 0 and reset zero.
// - reserved bits read as zero and ignore writes; software keeps them on updates.
// - bits 26, 25 and 24 gate analog comparators 2, 1 and 0 and reset to zero.
`timescale 1ns/1ps

module scg_sleep_gate
    import scg_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // avalon-mm slave
    input wire logic [SCG_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [SCG_DATA_W-1:0] i_avs_writedata,
    input wire logic [SCG_BE_W-1:0] i_avs_byteenable,
    output logic [SCG_DATA_W-1:0] o_avs_readdata,
    output logic [1:0] o_avs_response,
    output logic o_avs_waitrequest,
    // system mode
    input wire logic i_sleep_active,
    input wire logic [31:0] i_run_unit_clock_gate_1,
    // peripheral access check
    input wire logic i_periph_req,
    input wire logic [SCG_UNIT_W-1:0] i_periph_unit,
    output logic o_periph_done,
    output logic o_periph_fault,
    // unit clock enables
    output logic [31:0] o_unit_clk_en
);

    // ************************************************************
    // state
    // ************************************************************
    scg_bus_state_e bus_state_reg;
    scg_bus_state_e bus_state_next;
    logic [31:0] sleep_gate_reg;
    logic [31:0] sleep_gate_next;
    logic auto_gate_reg;
    logic auto_gate_next;
    logic fault_seen_reg;
    logic fault_seen_next;
    logic [SCG_UNIT_W-1:0] fault_unit_reg;
    logic [SCG_UNIT_W-1:0] fault_unit_next;
    logic [31:0] unit_en_reg;
    logic [31:0] unit_en_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [1:0] resp_reg;
    logic [1:0] resp_next;

    logic bus_req;
    logic bus_commit;
    logic wr_commit;
    logic hit_sleep;
    logic hit_status;
    logic hit_fault;
    logic hit_config;
    logic hit_any;
    logic [31:0] be_mask;
    logic [31:0] fault_word;
    logic use_sleep_word;
    logic chk_done;
    logic chk_fault;
    logic [SCG_UNIT_W-1:0] chk_unit;

    // ************************************************************
    // avalon handshake
    // ************************************************************
    // one wait state: the first cycle decodes and fetches, the second
    // answers; this keeps read data and response coming from flip-flops
    assign bus_req = i_avs_read | i_avs_write;
    assign bus_commit = bus_req & (bus_state_reg == SCG_BUS_DONE);
    assign wr_commit = bus_commit & i_avs_write;
    assign o_avs_waitrequest = bus_req & ~(bus_state_reg == SCG_BUS_DONE);
    assign o_avs_readdata = rdata_reg;
    assign o_avs_response = resp_reg;

    always_comb begin
        bus_state_next = bus_state_reg;
        case (bus_state_reg)
            SCG_BUS_IDLE: begin
                if (bus_req) begin
                    bus_state_next = SCG_BUS_DONE;
                end
            end
            SCG_BUS_DONE: begin
                bus_state_next = SCG_BUS_IDLE;
            end
            default: begin
                bus_state_next = SCG_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            bus_state_reg <= SCG_BUS_IDLE;
        end else begin
            bus_state_reg <= bus_state_next;
        end
    end

    // ************************************************************
    // address decode
    // ************************************************************
    assign hit_sleep = (i_avs_address == SCG_OFF_SLEEP_GATE);
    assign hit_status = (i_avs_address == SCG_OFF_GATE_STATUS);
    assign hit_fault = (i_avs_address == SCG_OFF_FAULT_STATUS);
    assign hit_config = (i_avs_address == SCG_OFF_CLOCK_CONFIG);
    assign hit_any = hit_sleep | hit_status | hit_fault | hit_config;

    // byte enables widened to a bit mask
    genvar gb;
    generate
        for (gb = 0; gb < SCG_BE_W; gb++) begin : g_be
            assign be_mask[gb*8 +: 8] = {8{i_avs_byteenable[gb]}};
        end
    endgenerate

    // ************************************************************
    // sleep gating register
    // ************************************************************
    // reserved positions are masked on write so they stay zero
    always_comb begin
        sleep_gate_next = sleep_gate_reg;
        if (wr_commit && hit_sleep) begin
            sleep_gate_next = (sleep_gate_reg & ~(be_mask
                & SCG_SLEEP_GATE_WMASK))
                | (i_avs_writedata & be_mask
                & SCG_SLEEP_GATE_WMASK);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sleep_gate_reg <= SCG_SLEEP_GATE_RST;
        end else begin
            sleep_gate_reg <= sleep_gate_next;
        end
    end

    // ************************************************************
    // clock configuration: automatic gating select
    // ************************************************************
    always_comb begin
        auto_gate_next = auto_gate_reg;
        if (wr_commit && hit_config && i_avs_byteenable[0]) begin
            auto_gate_next = i_avs_writedata[SCG_BIT_AUTO_GATE];
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            auto_gate_reg <= SCG_AUTO_GATE_RST;
        end else begin
            auto_gate_reg <= auto_gate_next;
        end
    end

    // ************************************************************
    // unit clock enables
    // ************************************************************
    // sleep word applies only while sleeping with automatic gating on;
    // otherwise the run-mode word from outside steers the units
    assign use_sleep_word = i_sleep_active & auto_gate_reg;

    genvar gu;
    generate
        for (gu = 0; gu < 32; gu++) begin : g_unit
            // reserved positions never enable anything
            assign unit_en_next[gu] = SCG_SLEEP_GATE_WMASK[gu]
                & (use_sleep_word ? sleep_gate_reg[gu]
                : i_run_unit_clock_gate_1[gu]);
        end
    endgenerate

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            unit_en_reg <= SCG_ZERO_WORD;
        end else begin
            unit_en_reg <= unit_en_next;
        end
    end

    assign o_unit_clk_en = unit_en_reg;

    // ************************************************************
    // peripheral access check
    // ************************************************************
    // checked against the enables the units actually see this cycle
    scg_fault_check u_fault_check (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_req(i_periph_req),
        .i_unit(i_periph_unit),
        .i_unit_en(unit_en_reg),
        .o_done(chk_done),
        .o_fault(chk_fault),
        .o_unit(chk_unit)
    );

    assign o_periph_done = chk_done;
    assign o_periph_fault = chk_fault;

    // ************************************************************
    // fault record
    // ************************************************************
    // a new fault in the same cycle as a software clear keeps the flag
    always_comb begin
        fault_seen_next = fault_seen_reg;
        fault_unit_next = fault_unit_reg;
        if (wr_commit && hit_fault && i_avs_byteenable[0]
            && i_avs_writedata[SCG_BIT_FAULT_SEEN]) begin
            fault_seen_next = 1'b0;
        end
        if (chk_fault) begin
            fault_seen_next = 1'b1;
            fault_unit_next = chk_unit;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            fault_seen_reg <= 1'b0;
            fault_unit_reg <= '0;
        end else begin
            fault_seen_reg <= fault_seen_next;
            fault_unit_reg <= fault_unit_next;
        end
    end

    always_comb begin
        fault_word = SCG_ZERO_WORD;
        fault_word[SCG_BIT_FAULT_SEEN] = fault_seen_reg;
        fault_word[SCG_FAULT_UNIT_LSB +: SCG_UNIT_W] = fault_unit_reg;
    end

    // ************************************************************
    // read data and response
    // ************************************************************
    // fetched in the wait cycle, held through the answer cycle
    always_comb begin
        rdata_next = rdata_reg;
        resp_next = resp_reg;
        if (bus_req && bus_state_reg == SCG_BUS_IDLE) begin
            rdata_next = SCG_ZERO_WORD;
            resp_next = hit_any ? SCG_RESP_OKAY : SCG_RESP_DECODEERROR;
            if (i_avs_read) begin
                if (hit_sleep) begin
                    rdata_next = sleep_gate_reg & SCG_SLEEP_GATE_WMASK;
                end else if (hit_status) begin
                    rdata_next = unit_en_reg;
                end else if (hit_fault) begin
                    rdata_next = fault_word;
                end else if (hit_config) begin
                    rdata_next[SCG_BIT_AUTO_GATE] = auto_gate_reg;
                end
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_reg <= SCG_ZERO_WORD;
            resp_reg <= SCG_RESP_OKAY;
        end else begin
            rdata_reg <= rdata_next;
            resp_reg <= resp_next;
        end
    end

endmodule

// ### scg_sleep_gate_assertions.sv
/*
 * concurrent checks on the ports of scg_sleep_gate.
 * assumes the master keeps its request up until waitrequest is low.
 */
`timescale 1ns/1ps

module scg_sleep_gate_chk
    import scg_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // avalon-mm slave
    input wire logic [SCG_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [SCG_DATA_W-1:0] i_avs_writedata,
    input wire logic [SCG_BE_W-1:0] i_avs_byteenable,
    input wire logic [SCG_DATA_W-1:0] o_avs_readdata,
    input wire logic [1:0] o_avs_response,
    input wire logic o_avs_waitrequest,
    // system mode
    input wire logic i_sleep_active,
    input wire logic [31:0] i_run_unit_clock_gate_1,
    // peripheral access and enables
    input wire logic i_periph_req,
    input wire logic [SCG_UNIT_W-1:0] i_periph_unit,
    input wire logic o_periph_done,
    input wire logic o_periph_fault,
    input wire logic [31:0] o_unit_clk_en
);
    // ************************************************************
    // helpers
    // ************************************************************
    logic req;
    logic ans;
    logic mapped;
    logic waited_q;
    assign req = i_avs_read || i_avs_write;
    assign ans = req && !o_avs_waitrequest;
    assign mapped = i_avs_address inside {SCG_OFF_SLEEP_GATE,
        SCG_OFF_GATE_STATUS, SCG_OFF_FAULT_STATUS, SCG_OFF_CLOCK_CONFIG};
    // marks the cycle after a wait state, so a held request is not new
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn)
            waited_q <= 1'b0;
        else
            waited_q <= req && o_avs_waitrequest;
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    // ************************************************************
    // assertions
    // ************************************************************
    first_wait_a: assert property (req && !waited_q |-> o_avs_waitrequest)
        else $error("new request not held by a wait state");
    one_wait_a: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("request waited more than one cycle");
    unmapped_resp_a: assert property (ans && !mapped |->
        o_avs_response == SCG_RESP_DECODEERROR)
        else $error("unmapped access not refused");
    mapped_resp_a: assert property (ans && mapped |->
        o_avs_response == SCG_RESP_OKAY)
        else $error("mapped access not answered okay");
    sleep_rd_a: assert property (ans && i_avs_read &&
        i_avs_address == SCG_OFF_SLEEP_GATE |->
        (o_avs_readdata & ~SCG_SLEEP_GATE_WMASK) == 0)
        else $error("reserved sleep bits read nonzero");
    run_select_a: assert property (!i_sleep_active |=>
        o_unit_clk_en == ($past(i_run_unit_clock_gate_1) &
        SCG_SLEEP_GATE_WMASK))
        else $error("awake enables do not follow run word");
    en_reserved_a: assert property ((o_unit_clk_en &
        ~SCG_SLEEP_GATE_WMASK) == 0)
        else $error("enable on a reserved position");
    periph_fault_a: assert property (i_periph_req &&
        !o_unit_clk_en[i_periph_unit] |=> o_periph_fault && !o_periph_done)
        else $error("access to stopped unit not faulted");
    periph_done_a: assert property (i_periph_req &&
        o_unit_clk_en[i_periph_unit] |=> o_periph_done && !o_periph_fault)
        else $error("access to running unit not completed");
    periph_idle_a: assert property (!i_periph_req |=>
        !o_periph_done && !o_periph_fault)
        else $error("answer without an access");

    c_fault_c: cover property (i_periph_req ##1 o_periph_fault);
    c_done_c: cover property (i_periph_req ##1 o_periph_done);
    c_unmapped_c: cover property (ans && !mapped);
endmodule

bind scg_sleep_gate scg_sleep_gate_chk u_chk (
    .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_response(o_avs_response),
    .o_avs_waitrequest(o_avs_waitrequest), .i_sleep_active(i_sleep_active),
    .i_run_unit_clock_gate_1(i_run_unit_clock_gate_1),
    .i_periph_req(i_periph_req), .i_periph_unit(i_periph_unit),
    .o_periph_done(o_periph_done), .o_periph_fault(o_periph_fault),
    .o_unit_clk_en(o_unit_clk_en)
);

// ### sleep_mode_peripheral_clock_gating_tb_top.sv
/*
 * self-checking bench for scg_sleep_gate over avalon-mm.
 * assumes the checker file is compiled alongside and binds itself.
 */
`timescale 1ns/1ps

module sleep_mode_peripheral_clock_gating_tb_top
    import scg_pkg::*;
();
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic rd, wr, slp, preq, wreq, pdone, pfault;
    logic [11:0] adr;
    logic [31:0] wd, rdata, run, en, q;
    logic [3:0] be;
    logic [1:0] resp, r;
    logic [4:0] punit;
    int err_count = 0;
    int checks = 0;

    always #(SCG_CLK_PERIOD_NS / 2) clk = ~clk;

    scg_sleep_gate dut (
        .i_ref_clk(clk), .i_rstn(rstn), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .i_avs_byteenable(be), .o_avs_readdata(rdata),
        .o_avs_response(resp), .o_avs_waitrequest(wreq),
        .i_sleep_active(slp), .i_run_unit_clock_gate_1(run),
        .i_periph_req(preq), .i_periph_unit(punit),
        .o_periph_done(pdone), .o_periph_fault(pfault), .o_unit_clk_en(en)
    );

    // ************************************************************
    // compare and access tasks
    // ************************************************************
    task automatic cmp_word(input string nm, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmp_code(input string nm, input logic [1:0] e, g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // the answer edge is the only one where data and response are taken
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] b);
        int n;
        n = 0;
        @(posedge clk);
        rd <= ~w;
        wr <= w;
        adr <= a;
        wd <= d;
        be <= b;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        cmp_code("waitrequest", 2'h0, {1'b0, wreq});
        q = rdata;
        r = resp;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic chk_rd(input string nm, input logic [11:0] a,
        input logic [31:0] e);
        xfer(1'b0, a, 32'h0, 4'h0);
        cmp_word(nm, e, q);
        cmp_code("response", SCG_RESP_OKAY, r);
    endtask

    task automatic poke(input logic [4:0] u, input logic [1:0] e);
        @(posedge clk);
        preq <= 1'b1;
        punit <= u;
        @(posedge clk);
        preq <= 1'b0;
        @(posedge clk);
        cmp_code("periph done fault", e, {pdone, pfault});
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        {rd, wr, slp, preq, adr, wd, be, run, punit} = '0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        chk_rd("sleep gate", SCG_OFF_SLEEP_GATE, SCG_SLEEP_GATE_RST);
        chk_rd("clock config", SCG_OFF_CLOCK_CONFIG, 32'h0);
        chk_rd("gate status", SCG_OFF_GATE_STATUS, 32'h0);
        $display("test reset values done");

        // a walking one shows every writable and every reserved position
        for (int b = 0; b < 32; b++) begin
            xfer(1'b1, SCG_OFF_SLEEP_GATE, 32'h1 << b, 4'hf);
            chk_rd("sleep bit", SCG_OFF_SLEEP_GATE,
                (32'h1 << b) & SCG_SLEEP_GATE_WMASK);
        end
        xfer(1'b1, SCG_OFF_SLEEP_GATE, 32'h0, 4'hf);
        xfer(1'b1, SCG_OFF_SLEEP_GATE, 32'hffff_ffff, 4'h2);
        chk_rd("byte lane", SCG_OFF_SLEEP_GATE, 32'h0000_5300);
        $display("test register fields done");

        run <= 32'hffff_ffff;
        repeat (3) @(posedge clk);
        cmp_word("run enables", SCG_SLEEP_GATE_WMASK, en);
        xfer(1'b1, SCG_OFF_SLEEP_GATE, 32'h0100_0002, 4'hf);
        slp <= 1'b1;
        repeat (3) @(posedge clk);
        cmp_word("no auto select", SCG_SLEEP_GATE_WMASK, en);
        xfer(1'b1, SCG_OFF_CLOCK_CONFIG, 32'h1, 4'hf);
        repeat (3) @(posedge clk);
        cmp_word("sleep enables", 32'h0100_0002, en);
        chk_rd("gate status", SCG_OFF_GATE_STATUS, 32'h0100_0002);
        $display("test enable select done");

        poke(5'd1, 2'b10);
        poke(5'd24, 2'b10);
        poke(5'd0, 2'b01);
        poke(5'd3, 2'b01);
        chk_rd("fault status", SCG_OFF_FAULT_STATUS, 32'h0000_0301);
        xfer(1'b1, SCG_OFF_FAULT_STATUS, 32'h1, 4'hf);
        xfer(1'b0, SCG_OFF_FAULT_STATUS, 32'h0, 4'h0);
        cmp_word("fault cleared", 32'h0, q & 32'h1);
        slp <= 1'b0;
        repeat (3) @(posedge clk);
        poke(5'd0, 2'b10);
        $display("test access faults done");

        xfer(1'b1, 12'h200, 32'hffff_ffff, 4'hf);
        cmp_code("unmapped write", SCG_RESP_DECODEERROR, r);
        xfer(1'b0, 12'h200, 32'h0, 4'h0);
        cmp_code("unmapped read", SCG_RESP_DECODEERROR, r);
        cmp_word("unmapped data", 32'h0, q);
        chk_rd("sleep kept", SCG_OFF_SLEEP_GATE, 32'h0100_0002);
        $display("test unmapped done");

        // a second reset in mid-run must clear what software set
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        chk_rd("sleep gate", SCG_OFF_SLEEP_GATE, SCG_SLEEP_GATE_RST);
        chk_rd("clock config", SCG_OFF_CLOCK_CONFIG, 32'h0);
        $display("test second reset done");
        print_verdict();
    end

    initial begin
        #(SCG_CLK_PERIOD_NS * 5000);
        err_count++;
        print_verdict();
    end
endmodule
